// ---- hdl/fupc_ctrl.sv ----
// flash user erase/program controller: registers, sequencer and cpu stall
`timescale 1ns/1ps
`default_nettype none

//
// Function
// (RULE1) only whole-sector erase exists in user program mode
// (RULE2) array holds 64 or 32 sectors of 128 bytes each
// (RULE3) software erases the target sector before programming bytes there
// (RULE4) erase lasts at least 4 ms after its start
// (RULE5) no sector erase while a tool program mode is active
// (RULE6) erase sequence: key, sector address, control 10100001B, key cleared
// (RULE7) software writes the key right before starting an erase
// (RULE8) start bit 0 to 1 with valid key erases, then self-clears
// (RULE9) start with invalid key erases nothing and start bit stays set
// (RULE10) bytes programmed one at a time by table store instructions
// (RULE11) program sequence: key, control 0101000XB, store, key cleared
// (RULE12) software loads the sector base before each byte write
// (RULE13) software gives address as register pair and data in register
// (RULE14) programming ignores the start bit value
// (RULE15) key resets to zero; only 10100101B enables user programming
// (RULE16) cpu stalls during erase and resumes on its own
// (RULE17) sector address low bits 6 to 0 are ignored
// (RULE18) table stores without a valid key leave the array untouched
module fupc_ctrl #(
    parameter int ERASE_CYCLES = fupc_pkg::ERASE_CYCLES
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // register port
    input wire fupc_pkg::fupc_reg_req_s reg_req_i,
    output logic [7:0] reg_rdata_o,
    // table store from cpu
    input wire fupc_pkg::fupc_store_s store_i,
    // device state
    input wire logic tool_mode_i,
    input wire logic small_array_i,
    // flash array and cpu
    output fupc_pkg::fupc_flash_cmd_s flash_cmd_o,
    output logic cpu_stall_o
);

    // ****************************************
    // helpers
    // ****************************************
    // sector index from the address pair; the small array has no top sector bit
    function automatic logic [fupc_pkg::SECTOR_W-1:0] sector_of(
        input logic [7:0] hi,
        input logic [7:0] lo,
        input logic half_size
    );
        logic [fupc_pkg::SECTOR_W-1:0] s;
        s = {hi[fupc_pkg::SECTOR_W-2:0], lo[7]}; // RULE17
        if (half_size)
        begin
            s[fupc_pkg::SECTOR_W-1] = 1'b0; // RULE2
        end
        return s;
    endfunction

    // ****************************************
    // state
    // ****************************************
    fupc_pkg::fupc_state_e state;
    fupc_pkg::fupc_state_e next_state;
    logic [7:0] unlock_key;
    logic [7:0] next_unlock_key;
    logic [7:0] op_ctl;
    logic [7:0] next_op_ctl;
    logic [7:0] sec_hi;
    logic [7:0] next_sec_hi;
    logic [7:0] sec_lo;
    logic [7:0] next_sec_lo;
    logic [fupc_pkg::TIMER_W-1:0] timer;
    logic [fupc_pkg::TIMER_W-1:0] next_timer;
    fupc_pkg::fupc_flash_cmd_s next_flash_cmd;
    logic [7:0] next_rdata;

    logic key_valid;
    logic idle;
    logic wr_ctl;
    logic erase_go;
    logic erase_refused;
    logic store_go;
    logic [fupc_pkg::SECTOR_W-1:0] cur_sector;

    assign key_valid = (unlock_key == fupc_pkg::KEY_VALUE); // RULE15
    assign idle = (state == fupc_pkg::FUPC_IDLE);
    assign wr_ctl = reg_req_i.wr && (reg_req_i.addr == fupc_pkg::REG_CTL) && idle;
    assign cur_sector = sector_of(sec_hi, sec_lo, small_array_i);

    // start is a 0 to 1 edge of the start bit with erase mode selected
    assign erase_go = wr_ctl && reg_req_i.wdata[fupc_pkg::START_BIT]
        && !op_ctl[fupc_pkg::START_BIT]
        && (reg_req_i.wdata[7:1] == fupc_pkg::CTL_MODE_ERASE)
        && key_valid && !tool_mode_i; // RULE8 RULE5
    assign erase_refused = wr_ctl && reg_req_i.wdata[fupc_pkg::START_BIT]
        && !op_ctl[fupc_pkg::START_BIT]
        && (reg_req_i.wdata[7:1] == fupc_pkg::CTL_MODE_ERASE)
        && !(key_valid && !tool_mode_i); // RULE9
    // start bit plays no part in programming
    assign store_go = store_i.valid && idle && key_valid && !tool_mode_i
        && (op_ctl[7:1] == fupc_pkg::CTL_MODE_PROG); // RULE14 RULE18 RULE10

    // stall while the array is busy; covers erase and byte program
    assign cpu_stall_o = !idle; // RULE16

    // ****************************************
    // next values
    // ****************************************
    always_comb
    begin
        next_state = state;
        next_timer = timer;
        next_unlock_key = unlock_key;
        next_op_ctl = op_ctl;
        next_sec_hi = sec_hi;
        next_sec_lo = sec_lo;
        next_flash_cmd = '0;
        next_rdata = fupc_pkg::RD_ZERO;
        if (reg_req_i.wr && idle)
        begin
            unique case (reg_req_i.addr)
                fupc_pkg::REG_KEY: next_unlock_key = reg_req_i.wdata;
                fupc_pkg::REG_CTL: next_op_ctl = reg_req_i.wdata;
                fupc_pkg::REG_SEC_HI: next_sec_hi = reg_req_i.wdata;
                fupc_pkg::REG_SEC_LO: next_sec_lo = reg_req_i.wdata;
                default: next_unlock_key = unlock_key;
            endcase
        end
        if (reg_req_i.rd)
        begin
            unique case (reg_req_i.addr)
                fupc_pkg::REG_KEY: next_rdata = unlock_key;
                fupc_pkg::REG_CTL: next_rdata = op_ctl;
                fupc_pkg::REG_SEC_HI: next_rdata = sec_hi;
                fupc_pkg::REG_SEC_LO: next_rdata = sec_lo;
                fupc_pkg::REG_STATUS:
                begin
                    next_rdata[fupc_pkg::STAT_BUSY] = !idle;
                    next_rdata[fupc_pkg::STAT_KEY] = key_valid;
                    next_rdata[fupc_pkg::STAT_TOOL] = tool_mode_i;
                    next_rdata[fupc_pkg::STAT_ERASING] = (state == fupc_pkg::FUPC_ERASE);
                end
                default: next_rdata = fupc_pkg::RD_ZERO;
            endcase
        end
        unique case (state)
            fupc_pkg::FUPC_IDLE:
            begin
                if (erase_go)
                begin
                    // whole sector only, offset forced to zero
                    next_state = fupc_pkg::FUPC_ERASE; // RULE1
                    next_timer = fupc_pkg::TIMER_W'(ERASE_CYCLES - 1); // RULE4
                    next_flash_cmd.erase = 1'b1;
                    next_flash_cmd.addr = {sector_of(sec_hi, sec_lo, small_array_i),
                        fupc_pkg::OFFSET_ZERO}; // RULE17
                end
                else if (store_go)
                begin
                    next_state = fupc_pkg::FUPC_PROG;
                    next_timer = fupc_pkg::TIMER_W'(fupc_pkg::PROG_CYCLES - 1);
                    next_flash_cmd.prog_byte = 1'b1;
                    next_flash_cmd.addr = {cur_sector, store_i.addr[fupc_pkg::OFFSET_W-1:0]};
                    next_flash_cmd.data = store_i.data;
                end
            end
            fupc_pkg::FUPC_ERASE, fupc_pkg::FUPC_PROG:
            begin
                if (timer == fupc_pkg::TIMER_ZERO)
                begin
                    next_state = fupc_pkg::FUPC_IDLE;
                    if (state == fupc_pkg::FUPC_ERASE)
                    begin
                        next_op_ctl[fupc_pkg::START_BIT] = 1'b0; // RULE8
                    end
                end
                else
                begin
                    next_timer = timer - fupc_pkg::TIMER_ONE;
                end
            end
            default: next_state = fupc_pkg::FUPC_IDLE;
        endcase
        // a refused start simply keeps the written start bit; nothing clears it
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            state <= fupc_pkg::FUPC_IDLE;
            timer <= fupc_pkg::TIMER_ZERO;
            unlock_key <= fupc_pkg::KEY_RESET; // RULE15
            op_ctl <= fupc_pkg::CTL_RESET;
            sec_hi <= fupc_pkg::SEC_RESET;
            sec_lo <= fupc_pkg::SEC_RESET;
            flash_cmd_o <= '0;
            reg_rdata_o <= fupc_pkg::RD_ZERO;
        end
        else
        begin
            state <= next_state;
            timer <= next_timer;
            unlock_key <= next_unlock_key;
            op_ctl <= next_op_ctl;
            sec_hi <= next_sec_hi;
            sec_lo <= next_sec_lo;
            flash_cmd_o <= next_flash_cmd;
            reg_rdata_o <= next_rdata;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sequence s_bad_start;
        erase_refused;
    endsequence

    sequence s_erase_launch;
        erase_go ##1 flash_cmd_o.erase;
    endsequence

    a_erase_needs_key: assert property ( // RULE15
        @(posedge core_clk_i) disable iff (rst_i)
        flash_cmd_o.erase |-> $past(unlock_key) == fupc_pkg::KEY_VALUE)
        else $error("erase launched without unlock key");

    a_tool_blocks_erase: assert property ( // RULE5
        @(posedge core_clk_i) disable iff (rst_i)
        tool_mode_i |=> !flash_cmd_o.erase)
        else $error("erase launched in tool mode");

    a_erase_holds_time: assert property ( // RULE4
        @(posedge core_clk_i) disable iff (rst_i)
        (state == fupc_pkg::FUPC_ERASE && timer != fupc_pkg::TIMER_ZERO)
        |=> state == fupc_pkg::FUPC_ERASE)
        else $error("erase ended before its time");

    a_erase_stalls_cpu: assert property ( // RULE16
        @(posedge core_clk_i) disable iff (rst_i)
        s_erase_launch |-> cpu_stall_o && state == fupc_pkg::FUPC_ERASE)
        else $error("cpu not stalled by erase");

    a_start_self_clear: assert property ( // RULE8
        @(posedge core_clk_i) disable iff (rst_i)
        $fell(state == fupc_pkg::FUPC_ERASE) |-> !op_ctl[0] && !cpu_stall_o)
        else $error("start bit not cleared after erase");

    a_bad_start_stays: assert property ( // RULE9
        @(posedge core_clk_i) disable iff (rst_i)
        s_bad_start |=> op_ctl[0] && idle && !flash_cmd_o.erase)
        else $error("refused start erased or cleared");

    a_sector_aligned: assert property ( // RULE17
        @(posedge core_clk_i) disable iff (rst_i)
        flash_cmd_o.erase |-> flash_cmd_o.addr[fupc_pkg::OFFSET_W-1:0] == fupc_pkg::OFFSET_ZERO)
        else $error("erase address not sector aligned");

    a_store_blocked: assert property ( // RULE18
        @(posedge core_clk_i) disable iff (rst_i)
        (store_i.valid && !key_valid) |=> !flash_cmd_o.prog_byte)
        else $error("store programmed without key");

    a_store_programs: assert property ( // RULE14
        @(posedge core_clk_i) disable iff (rst_i)
        store_go |=> flash_cmd_o.prog_byte && flash_cmd_o.data == $past(store_i.data)
        && cpu_stall_o)
        else $error("accepted store did not program");

    a_key_reset: assert property ( // RULE15
        @(posedge core_clk_i)
        rst_i |=> unlock_key == fupc_pkg::KEY_RESET && !cpu_stall_o)
        else $error("unlock key not cleared by reset");

endmodule // fupc_ctrl

`default_nettype wire

// ---- hdl/fupc_pkg.sv ----
// shared constants, states and carriers of the flash user erase/program controller
package fupc_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [2:0] REG_KEY = 3'h0;
    localparam logic [2:0] REG_CTL = 3'h1;
    localparam logic [2:0] REG_SEC_HI = 3'h2;
    localparam logic [2:0] REG_SEC_LO = 3'h3;
    localparam logic [2:0] REG_STATUS = 3'h4;

    // ****************************************
    // values and fields
    // ****************************************
    localparam logic [7:0] KEY_VALUE = 8'ha5;
    localparam logic [7:0] KEY_RESET = 8'h00;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] SEC_RESET = 8'h00;
    localparam logic [7:0] RD_ZERO = 8'h00;
    localparam logic [6:0] CTL_MODE_ERASE = 7'h50;
    localparam logic [6:0] CTL_MODE_PROG = 7'h28;
    localparam int START_BIT = 0;
    localparam int STAT_BUSY = 0;
    localparam int STAT_KEY = 1;
    localparam int STAT_TOOL = 2;
    localparam int STAT_ERASING = 3;
    localparam int OFFSET_W = 7;
    localparam int SECTOR_W = 6;
    localparam int ADDR_W = 13;
    localparam int SEC_HI_W = 6;
    localparam logic [OFFSET_W-1:0] OFFSET_ZERO = 7'h00;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int ERASE_TIME_MS = 4;
    localparam int PROG_TIME_US = 25;
    localparam int ERASE_CYCLES = (ERASE_TIME_MS * CLK_HZ + 999) / 1000;
    localparam int PROG_CYCLES = (PROG_TIME_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int TIMER_W = 17;
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 17'h0_0000;
    localparam logic [TIMER_W-1:0] TIMER_ONE = 17'h0_0001;

    // ****************************************
    // states and carriers
    // ****************************************
    typedef enum logic [1:0] {
        FUPC_IDLE = 2'b00,
        FUPC_ERASE = 2'b01,
        FUPC_PROG = 2'b10
    } fupc_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } fupc_reg_req_s;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [7:0] data;
    } fupc_store_s;

    typedef struct packed {
        logic erase;
        logic prog_byte;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } fupc_flash_cmd_s;

endpackage

// ---- bench/fupc_cpu_model.sv ----
// cpu core model: register accesses and table stores toward the controller
`timescale 1ns/1ps
`default_nettype none
module fupc_cpu_model (
    // clock and controller state
    input wire logic core_clk_i,
    input wire logic cpu_stall_i,
    input wire logic [7:0] reg_rdata_i,
    // requests
    output fupc_pkg::fupc_reg_req_s reg_req_o,
    output fupc_pkg::fupc_store_s store_o
);
    // stall waits that ran out of their bound
    int n_hang = 0;
    initial
    begin
        reg_req_o = '0;
        store_o = '0;
    end
    // a stalled core waits up to 1000 cycles before a register access, then counts a hang
    task automatic hold_off();
        #1;
        for (int i = 0; i < 1000 && cpu_stall_i; i++)
            @(posedge core_clk_i);
        if (cpu_stall_i !== 1'b0)
            n_hang++;
    endtask
    // released lines show inverted values, never the old request
    task automatic issue(input logic wr, input logic [2:0] a, input logic [7:0] d,
                         output logic [7:0] q);
        hold_off();
        @(posedge core_clk_i);
        reg_req_o <= '{wr: wr, rd: !wr, addr: a, wdata: d};
        @(posedge core_clk_i);
        reg_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        #1;
        q = reg_rdata_i;
    endtask
    task automatic erase_seq(input logic [7:0] key, input logic [7:0] hi, input logic [7:0] lo);
        logic [7:0] q;
        issue(1'b1, fupc_pkg::REG_CTL, 8'ha0, q);
        issue(1'b1, fupc_pkg::REG_KEY, key, q);
        issue(1'b1, fupc_pkg::REG_SEC_HI, hi, q);
        issue(1'b1, fupc_pkg::REG_SEC_LO, lo, q);
        issue(1'b1, fupc_pkg::REG_CTL, 8'ha1, q);
        issue(1'b1, fupc_pkg::REG_KEY, 8'h00, q);
    endtask
    task automatic prog_seq(input logic [7:0] key, input logic b0, input logic [7:0] hi,
                            input logic [7:0] lo, input logic [15:0] a, input logic [7:0] d);
        logic [7:0] q;
        issue(1'b1, fupc_pkg::REG_KEY, key, q);
        issue(1'b1, fupc_pkg::REG_CTL, {fupc_pkg::CTL_MODE_PROG, b0}, q);
        issue(1'b1, fupc_pkg::REG_SEC_HI, hi, q);
        issue(1'b1, fupc_pkg::REG_SEC_LO, lo, q);
        @(posedge core_clk_i);
        store_o <= '{valid: 1'b1, addr: a, data: d};
        @(posedge core_clk_i);
        store_o <= '{valid: 1'b0, addr: ~a, data: ~d};
        issue(1'b1, fupc_pkg::REG_KEY, 8'h00, q);
    endtask
endmodule // fupc_cpu_model
`default_nettype wire

// ---- bench/flash_user_erase_program_ctrl_bench.sv ----
// self-checking bench of the flash user erase/program controller
`timescale 1ns/1ps
`default_nettype none
module flash_user_erase_program_ctrl_bench;
    localparam int ERASE_N = 20;
    logic core_clk_i, rst_i, tool_mode_i, small_array_i, cpu_stall_o;
    logic [7:0] reg_rdata_o, q, bad;
    fupc_pkg::fupc_reg_req_s reg_req_i;
    fupc_pkg::fupc_store_s store_i;
    fupc_pkg::fupc_flash_cmd_s flash_cmd_o, last_cmd;
    int n_fail = 0, n_tests = 0, n_cmd = 0, n_stall = 0, c0, s0;
    logic [31:0] r = 32'h0000_7fb0;
    logic [12:0] base;
    fupc_ctrl #(.ERASE_CYCLES(ERASE_N)) dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .store_i(store_i),
        .tool_mode_i(tool_mode_i), .small_array_i(small_array_i),
        .flash_cmd_o(flash_cmd_o), .cpu_stall_o(cpu_stall_o));
    fupc_cpu_model cpu_u (.core_clk_i(core_clk_i), .cpu_stall_i(cpu_stall_o),
        .reg_rdata_i(reg_rdata_o), .reg_req_o(reg_req_i), .store_o(store_i));
    initial
    begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i)
    begin
        if (cpu_stall_o === 1'b1) n_stall <= n_stall + 1;
        if (flash_cmd_o.erase === 1'b1 || flash_cmd_o.prog_byte === 1'b1)
        begin
            n_cmd <= n_cmd + 1;
            last_cmd <= flash_cmd_o;
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        for (int i = 0; i < 32; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
        return s;
    endfunction
    // sector base; the 32-sector variant has no top sector bit
    function automatic logic [12:0] exp_base(input logic [7:0] hi, input logic [7:0] lo,
                                             input logic half_size);
        logic [5:0] s;
        s = {hi[4:0], lo[7]};
        if (half_size) s[5] = 1'b0;
        return {s, 7'h00};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic mark();
        c0 = n_cmd;
        s0 = n_stall;
    endtask
    task automatic expect_op(input int n, input int st);
        chk(32'(n_cmd - c0), 32'(n));
        chk(32'(n_stall - s0), 32'(st));
    endtask
    task automatic wrap_up();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        for (int i = 0; i < 100000; i++) @(posedge core_clk_i);
        n_fail++;
        wrap_up();
    end
    initial
    begin
        rst_i = 1'b1;
        tool_mode_i = 1'b0;
        small_array_i = 1'b0;
        repeat (6) @(posedge core_clk_i);
        rst_i <= 1'b0;
        // reset values, status and unmapped offsets all read zero
        for (int a = 0; a < 8; a++)
        begin
            cpu_u.issue(1'b0, a[2:0], 8'h00, q);
            chk(32'(q), 32'h0000_0000);
        end
        for (int k = 0; k < 6; k++)
        begin
            r = lfsr(r);
            @(posedge core_clk_i) small_array_i <= r[0];
            base = exp_base(r[15:8], r[23:16], r[0]);
            mark();
            cpu_u.erase_seq(fupc_pkg::KEY_VALUE, r[15:8], r[23:16]);
            expect_op(1, ERASE_N);
            chk({last_cmd.erase, last_cmd.prog_byte, last_cmd.addr}, {2'b10, base});
            cpu_u.issue(1'b0, fupc_pkg::REG_CTL, 8'h00, q);
            chk(32'(q), 32'h0000_00a0);
            // erased sector first, then a byte inside it
            mark();
            cpu_u.prog_seq(fupc_pkg::KEY_VALUE, r[4], r[15:8], r[23:16],
                           {r[15:8], r[23], r[30:24]}, r[31:24]);
            expect_op(1, fupc_pkg::PROG_CYCLES);
            chk({last_cmd.erase, last_cmd.prog_byte, last_cmd.addr, last_cmd.data},
                {2'b01, base | {6'h00, r[30:24]}, r[31:24]});
            bad = (r[7:0] == fupc_pkg::KEY_VALUE) ? 8'h5a : r[7:0];
            mark();
            cpu_u.erase_seq(bad, r[15:8], r[23:16]);
            expect_op(0, 0);
            cpu_u.issue(1'b0, fupc_pkg::REG_CTL, 8'h00, q);
            chk(32'(q), 32'h0000_00a1);
            @(posedge core_clk_i) tool_mode_i <= 1'b1;
            mark();
            cpu_u.erase_seq(fupc_pkg::KEY_VALUE, r[15:8], r[23:16]);
            // tool mode also shuts out byte programming
            cpu_u.prog_seq(fupc_pkg::KEY_VALUE, r[5], r[15:8], r[23:16],
                           {r[15:8], r[23], r[30:24]}, r[31:24]);
            expect_op(0, 0);
            @(posedge core_clk_i) tool_mode_i <= 1'b0;
            mark();
            cpu_u.prog_seq(bad, r[5], r[15:8], r[23:16], {r[15:8], r[23], r[30:24]}, r[31:24]);
            expect_op(0, 0);
        end
        chk(32'(cpu_u.n_hang), 32'h0000_0000);
        wrap_up();
    end
endmodule // flash_user_erase_program_ctrl_bench
`default_nettype wire
